// >>> include/hmmd_cfg.svh
// Address map constants for the host memory map decoder.
// Assumes 16-bit instruction and data addresses from the 8-bit core.
`ifndef HMMD_CFG_SVH
`define HMMD_CFG_SVH

`define HMMD_ADDR_W          16
`define HMMD_DATA_W          8
`define HMMD_INSN_W          22
`define HMMD_ROM_WORDS       4096
`define HMMD_ROM_LO          16'h0000
`define HMMD_ROM_HI          16'h0fff
`define HMMD_IRAM_LO         16'h2000
`define HMMD_IRAM_HI         16'hbfff
`define HMMD_IRAM_DBG_LO     16'hbfb0
`define HMMD_VEC_START       16'h2000
`define HMMD_VEC_MID         16'h2001
`define HMMD_VEC_LOW         16'h2002
`define HMMD_VEC_HIGH        16'h2003
`define HMMD_VEC_RSVD        16'h2004
`define HMMD_DRAM_LO         16'h2000
`define HMMD_DRAM_HI         16'h3fef
`define HMMD_DRAM_DBG_LO     16'h3ff0
`define HMMD_DRAM_DBG_HI     16'h3fff
`define HMMD_SYS_LO          16'h0010
`define HMMD_SYS_HI          16'h001f
`define HMMD_PORTA_LO        16'h0020
`define HMMD_PORTA_HI        16'h0027
`define HMMD_PORTB_LO        16'h0028
`define HMMD_PORTB_HI        16'h002d
`define HMMD_UART_LO         16'h0030
`define HMMD_UART_HI         16'h0037
`define HMMD_EVT_LO          16'h003c
`define HMMD_EVT_HI          16'h003f
`define HMMD_IRQ_LO          16'h0040
`define HMMD_IRQ_HI          16'h0047
`define HMMD_PMU_LO          16'h0048
`define HMMD_PMU_HI          16'h004c
`define HMMD_HCI_LO          16'h0050
`define HMMD_HCI_HI          16'h0057
`define HMMD_CNT_LO          16'h0058
`define HMMD_CNT_HI          16'h005f
`define HMMD_SPI_LO          16'h0068
`define HMMD_SPI_HI          16'h006f
`define HMMD_SEQ_LO          16'h007c
`define HMMD_SEQ_HI          16'h007d
`define HMMD_DBGIF_LO        16'h0080
`define HMMD_DBGIF_HI        16'h009f
`define HMMD_CODEC_LO        16'h00e0
`define HMMD_CODEC_HI        16'h00ff
`define HMMD_PAGE0_HI        16'h00ff

`endif

// >>> include/hmmd_pkg.sv
// Types shared by the host memory map decoder files.
// Assumes hmmd_cfg.svh constants for widths.
package hmmd_pkg;

	// Instruction-side targets, one-hot
	typedef enum logic [3:0] {
		HMMD_I_NONE = 4'b0001,
		HMMD_I_ROM  = 4'b0010,
		HMMD_I_RAM  = 4'b0100,
		HMMD_I_DBG  = 4'b1000
	} hmmd_isel_t;

	typedef struct packed {
		logic        rom;
		logic        iram;
		logic        iram_dbg;
		logic        vector;
		logic [2:0]  vec_idx;
		logic        unmapped;
	} hmmd_ihit_t;

	typedef struct packed {
		logic sys;
		logic porta;
		logic portb;
		logic uart;
		logic evt;
		logic irq;
		logic pmu;
		logic hci;
		logic cnt;
		logic spi;
		logic seq;
		logic dbgif;
		logic codec;
		logic dram;
		logic dram_dbg;
		logic unmapped;
	} hmmd_dsel_t;

	typedef struct packed {
		logic [15:0] addr;
		logic        rd;
		logic        wr;
	} hmmd_dreq_t;

endpackage

// >>> src/hmmd_window.sv
// Inclusive address window comparator.
// Assumes a combinational address from the core on the same clock.
module hmmd_window #(
	parameter int          AW = 16,
	parameter logic [15:0] LO = 16'h0000,
	parameter logic [15:0] HI = 16'h0000
) (
	input  wire logic [AW-1:0] addr_in,
	input  wire logic          en_in,
	output logic               hit_out
);
	always_comb begin
		hit_out = en_in && (addr_in >= AW'(LO)) && (addr_in <= AW'(HI));
	end
endmodule

// >>> src/hmmd_decoder.sv
// Host memory map decoder: instruction and data space selects.
// Assumes the 8-bit core presents addresses and strobes on sys_clk_in;
// targets sample their select in the same cycle as the strobe.
`include "hmmd_cfg.svh"

module hmmd_decoder #(
	parameter int AW        = `HMMD_ADDR_W,
	parameter int DW        = `HMMD_DATA_W,
	parameter int IW        = `HMMD_INSN_W,
	parameter int ROM_WORDS = `HMMD_ROM_WORDS
) (
	input  wire logic              sys_clk_in,
	input  wire logic              rstn_in,
	// Instruction side
	input  wire logic [AW-1:0]     iaddr_in,
	input  wire logic              ifetch_in,
	input  wire logic              app_mode_in,
	input  wire logic [IW-1:0]     rom_rdata_in,
	input  wire logic [IW-1:0]     iram_rdata_in,
	output logic                   rom_sel_out,
	output logic [$clog2(ROM_WORDS)-1:0] rom_addr_out,
	output logic                   iram_sel_out,
	output logic [AW-1:0]          iram_addr_out,
	output logic [IW-1:0]          insn_out,
	output logic                   vector_hit_out,
	output logic [2:0]             vector_idx_out,
	output logic                   ifetch_err_out,
	output hmmd_pkg::hmmd_isel_t   isel_out,
	// Data side
	input  wire hmmd_pkg::hmmd_dreq_t dreq_in,
	input  wire logic              dbg_mode_in,
	input  wire logic [DW-1:0]     dram_rdata_in,
	input  wire logic [DW-1:0]     periph_rdata_in,
	output hmmd_pkg::hmmd_dsel_t   dsel_out,
	output logic                   dram_wr_out,
	output logic                   periph_wr_out,
	output logic                   periph_rd_out,
	output logic [DW-1:0]          drdata_out,
	output logic                   dacc_err_out,
	output logic [7:0]             derr_cnt_out
);

	hmmd_pkg::hmmd_ihit_t ihit;
	hmmd_pkg::hmmd_dsel_t dsel;
	logic                 i_rom;
	logic                 i_ram;
	logic                 i_dbg;
	logic                 d_page0;
	logic                 d_any;
	logic                 d_acc;
	logic                 dbg_block;
	logic                 w_sys;
	logic                 w_porta;
	logic                 w_portb;
	logic                 w_uart;
	logic                 w_evt;
	logic                 w_irq;
	logic                 w_pmu;
	logic                 w_hci;
	logic                 w_cnt;
	logic                 w_spi;
	logic                 w_seq;
	logic                 w_dbgif;
	logic                 w_codec;
	logic                 w_dram;
	logic                 w_ddbg;
	logic [7:0]           derr_cnt_reg;
	logic [7:0]           derr_cnt_next;

	// Instruction space windows, own comparators from data side
	hmmd_window #(.AW(AW), .LO(`HMMD_ROM_LO), .HI(`HMMD_ROM_HI)) u_win_rom (
		.addr_in (iaddr_in),
		.en_in   (ifetch_in),
		.hit_out (i_rom)
	);
	hmmd_window #(.AW(AW), .LO(`HMMD_IRAM_LO), .HI(`HMMD_IRAM_HI)) u_win_iram (
		.addr_in (iaddr_in),
		.en_in   (ifetch_in),
		.hit_out (i_ram)
	);
	hmmd_window #(.AW(AW), .LO(`HMMD_IRAM_DBG_LO), .HI(`HMMD_IRAM_HI)) u_win_idbg (
		.addr_in (iaddr_in),
		.en_in   (ifetch_in),
		.hit_out (i_dbg)
	);

	always_comb begin
		ihit          = '0;
		ihit.rom      = i_rom;
		ihit.iram     = i_ram;
		ihit.iram_dbg = i_dbg;
		ihit.vector   = i_ram && (iaddr_in <= AW'(`HMMD_VEC_RSVD));
		ihit.vec_idx  = 3'h0;
		if (ihit.vector) begin
			ihit.vec_idx = 3'(iaddr_in - AW'(`HMMD_VEC_START));
		end
		ihit.unmapped = ifetch_in && !i_rom && !i_ram;
	end

	// Instruction routing, purely combinational
	always_comb begin
		rom_sel_out    = ihit.rom;
		rom_addr_out   = iaddr_in[$clog2(ROM_WORDS)-1:0];
		iram_sel_out   = ihit.iram;
		iram_addr_out  = iaddr_in - AW'(`HMMD_IRAM_LO);
		vector_hit_out = ihit.vector;
		vector_idx_out = ihit.vec_idx;
		// Flag application code running in the debugger's tail
		ifetch_err_out = ihit.unmapped || (ihit.iram_dbg && app_mode_in);
		insn_out       = '0;
		if (ihit.rom) begin
			insn_out = rom_rdata_in;
		end else if (ihit.iram) begin
			insn_out = iram_rdata_in;
		end
		case (1'b1)
			ihit.rom:      isel_out = hmmd_pkg::HMMD_I_ROM;
			ihit.iram_dbg: isel_out = hmmd_pkg::HMMD_I_DBG;
			ihit.iram:     isel_out = hmmd_pkg::HMMD_I_RAM;
			default:       isel_out = hmmd_pkg::HMMD_I_NONE;
		endcase
	end

	// Data space qualifiers, independent of instruction address
	always_comb begin
		d_acc   = dreq_in.rd || dreq_in.wr;
		d_page0 = d_acc && (dreq_in.addr <= AW'(`HMMD_PAGE0_HI));
	end

	// Peripheral windows gated by page zero, so none can match above it
	hmmd_window #(
		.AW (AW),
		.LO (`HMMD_SYS_LO),
		.HI (`HMMD_SYS_HI)
	) u_win_sys (
		.addr_in (dreq_in.addr),
		.en_in   (d_page0),
		.hit_out (w_sys)
	);
	hmmd_window #(
		.AW (AW),
		.LO (`HMMD_PORTA_LO),
		.HI (`HMMD_PORTA_HI)
	) u_win_porta (
		.addr_in (dreq_in.addr),
		.en_in   (d_page0),
		.hit_out (w_porta)
	);
	hmmd_window #(
		.AW (AW),
		.LO (`HMMD_PORTB_LO),
		.HI (`HMMD_PORTB_HI)
	) u_win_portb (
		.addr_in (dreq_in.addr),
		.en_in   (d_page0),
		.hit_out (w_portb)
	);
	hmmd_window #(
		.AW (AW),
		.LO (`HMMD_UART_LO),
		.HI (`HMMD_UART_HI)
	) u_win_uart (
		.addr_in (dreq_in.addr),
		.en_in   (d_page0),
		.hit_out (w_uart)
	);
	hmmd_window #(
		.AW (AW),
		.LO (`HMMD_EVT_LO),
		.HI (`HMMD_EVT_HI)
	) u_win_evt (
		.addr_in (dreq_in.addr),
		.en_in   (d_page0),
		.hit_out (w_evt)
	);
	hmmd_window #(
		.AW (AW),
		.LO (`HMMD_IRQ_LO),
		.HI (`HMMD_IRQ_HI)
	) u_win_irq (
		.addr_in (dreq_in.addr),
		.en_in   (d_page0),
		.hit_out (w_irq)
	);
	hmmd_window #(
		.AW (AW),
		.LO (`HMMD_PMU_LO),
		.HI (`HMMD_PMU_HI)
	) u_win_pmu (
		.addr_in (dreq_in.addr),
		.en_in   (d_page0),
		.hit_out (w_pmu)
	);
	hmmd_window #(
		.AW (AW),
		.LO (`HMMD_HCI_LO),
		.HI (`HMMD_HCI_HI)
	) u_win_hci (
		.addr_in (dreq_in.addr),
		.en_in   (d_page0),
		.hit_out (w_hci)
	);
	hmmd_window #(
		.AW (AW),
		.LO (`HMMD_CNT_LO),
		.HI (`HMMD_CNT_HI)
	) u_win_cnt (
		.addr_in (dreq_in.addr),
		.en_in   (d_page0),
		.hit_out (w_cnt)
	);
	hmmd_window #(
		.AW (AW),
		.LO (`HMMD_SPI_LO),
		.HI (`HMMD_SPI_HI)
	) u_win_spi (
		.addr_in (dreq_in.addr),
		.en_in   (d_page0),
		.hit_out (w_spi)
	);
	hmmd_window #(
		.AW (AW),
		.LO (`HMMD_SEQ_LO),
		.HI (`HMMD_SEQ_HI)
	) u_win_seq (
		.addr_in (dreq_in.addr),
		.en_in   (d_page0),
		.hit_out (w_seq)
	);
	// Debug window only for the debugger, never an app peripheral
	hmmd_window #(
		.AW (AW),
		.LO (`HMMD_DBGIF_LO),
		.HI (`HMMD_DBGIF_HI)
	) u_win_dbgif (
		.addr_in (dreq_in.addr),
		.en_in   (d_page0 && dbg_mode_in),
		.hit_out (w_dbgif)
	);
	hmmd_window #(
		.AW (AW),
		.LO (`HMMD_CODEC_LO),
		.HI (`HMMD_CODEC_HI)
	) u_win_codec (
		.addr_in (dreq_in.addr),
		.en_in   (d_page0),
		.hit_out (w_codec)
	);
	// Data RAM windows see the full address, not only page zero
	hmmd_window #(
		.AW (AW),
		.LO (`HMMD_DRAM_LO),
		.HI (`HMMD_DRAM_HI)
	) u_win_dram (
		.addr_in (dreq_in.addr),
		.en_in   (d_acc),
		.hit_out (w_dram)
	);
	hmmd_window #(
		.AW (AW),
		.LO (`HMMD_DRAM_DBG_LO),
		.HI (`HMMD_DRAM_DBG_HI)
	) u_win_ddbg (
		.addr_in (dreq_in.addr),
		.en_in   (d_acc),
		.hit_out (w_ddbg)
	);

	always_comb begin
		dsel          = '0;
		dsel.sys      = w_sys;
		dsel.porta    = w_porta;
		dsel.portb    = w_portb;
		dsel.uart     = w_uart;
		dsel.evt      = w_evt;
		dsel.irq      = w_irq;
		dsel.pmu      = w_pmu;
		dsel.hci      = w_hci;
		dsel.cnt      = w_cnt;
		dsel.spi      = w_spi;
		dsel.seq      = w_seq;
		dsel.dbgif    = w_dbgif;
		dsel.codec    = w_codec;
		dsel.dram     = w_dram;
		dsel.dram_dbg = w_ddbg && dbg_mode_in;
		d_any = dsel.sys || dsel.porta || dsel.portb || dsel.uart || dsel.evt
			|| dsel.irq || dsel.pmu || dsel.hci || dsel.cnt || dsel.spi
			|| dsel.seq || dsel.dbgif || dsel.codec || dsel.dram || dsel.dram_dbg;
		dsel.unmapped = d_acc && !d_any;
	end

	// Data strobes and read mux; unmapped reads return zero
	always_comb begin
		dsel_out      = dsel;
		dram_wr_out   = dreq_in.wr && (dsel.dram || dsel.dram_dbg);
		periph_wr_out = dreq_in.wr && !dsel.dram && !dsel.dram_dbg && !dsel.unmapped;
		periph_rd_out = dreq_in.rd && !dsel.dram && !dsel.dram_dbg && !dsel.unmapped;
		drdata_out    = '0;
		if (dreq_in.rd && (dsel.dram || dsel.dram_dbg)) begin
			drdata_out = dram_rdata_in;
		end else if (periph_rd_out) begin
			drdata_out = periph_rdata_in;
		end
		// Application touching debugger bytes counts as an error
		dbg_block    = w_ddbg && !dbg_mode_in;
		dacc_err_out = dsel.unmapped || dbg_block;
	end

	// Saturating count of refused data accesses, for debug visibility
	always_comb begin
		derr_cnt_next = derr_cnt_reg;
		if (dacc_err_out && (derr_cnt_reg != 8'hff)) begin
			derr_cnt_next = derr_cnt_reg + 8'h01;
		end
	end

	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			derr_cnt_reg <= 8'h00;
		end else begin
			derr_cnt_reg <= derr_cnt_next;
		end
	end

	assign derr_cnt_out = derr_cnt_reg;

endmodule

// >>> verification/hmmd_decoder_properties.sv
// Port-level checks for the host memory map decoder.
// Assumes a bind from the bench top file; one clock domain.
module hmmd_decoder_properties (
	input wire logic                 sys_clk_in,
	input wire logic                 rstn_in,
	input wire logic [15:0]          iaddr_in,
	input wire logic                 ifetch_in,
	input wire logic                 app_mode_in,
	input wire logic                 rom_sel_out,
	input wire logic [11:0]          rom_addr_out,
	input wire logic                 iram_sel_out,
	input wire logic                 vector_hit_out,
	input wire logic [2:0]           vector_idx_out,
	input wire logic                 ifetch_err_out,
	input wire hmmd_pkg::hmmd_dreq_t dreq_in,
	input wire logic                 dbg_mode_in,
	input wire hmmd_pkg::hmmd_dsel_t dsel_out,
	input wire logic                 dram_wr_out,
	input wire logic                 periph_wr_out,
	input wire logic [7:0]           drdata_out,
	input wire logic                 dacc_err_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic        acc;
	logic [15:0] da;
	assign acc = dreq_in.rd | dreq_in.wr;
	assign da  = dreq_in.addr;
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!rstn_in);

	rom_fetch_a: assert property (ifetch_in && iaddr_in <= 16'h0fff |->
		rom_sel_out && rom_addr_out == iaddr_in[11:0]) else $error("boot fetch");
	iram_fetch_a: assert property (ifetch_in && iaddr_in inside {[16'h2000:16'hbfff]} |->
		iram_sel_out && !rom_sel_out) else $error("ram fetch");
	vector_slot_a: assert property (ifetch_in && iaddr_in inside {[16'h2000:16'h2004]} |->
		vector_hit_out && vector_idx_out == iaddr_in[2:0]) else $error("vector");
	dbg_tail_a: assert property (ifetch_in && app_mode_in && iaddr_in >= 16'hbfb0 |->
		ifetch_err_out) else $error("debug tail");
	space_split_a: assert property (ifetch_in && acc && iaddr_in == da && da <= 16'h00ff |->
		rom_sel_out && !iram_sel_out && !dsel_out.dram) else $error("space split");
	dram_dbg_a: assert property (acc && !dbg_mode_in && da inside {[16'h3ff0:16'h3fff]} |->
		dacc_err_out && !dram_wr_out) else $error("debug bytes");
	page_zero_a: assert property (acc && da > 16'h00ff |->
		dsel_out[15:3] == 13'h0000) else $error("page zero");
	dbg_window_a: assert property (acc && !dbg_mode_in && da inside {[16'h0080:16'h009f]} |->
		!dsel_out.dbgif && !periph_wr_out) else $error("debug window");
	unmapped_a: assert property (acc && da inside {[16'h0038:16'h003b], [16'h0100:16'h1fff]} |->
		dsel_out.unmapped && !periph_wr_out && drdata_out == 8'h00) else $error("unmapped");
endmodule

// >>> verification/hmmd_target_model.sv
// Read-data model of the memories and peripherals behind the decoder.
// Assumes combinational reads; instruction reads addressed by the decoder outputs, data reads by dreq_in.addr.
module hmmd_target_model (
	input  wire logic                 rom_sel_in,
	input  wire logic [11:0]          rom_addr_in,
	input  wire logic                 iram_sel_in,
	input  wire logic [15:0]          iram_addr_in,
	input  wire hmmd_pkg::hmmd_dreq_t dreq_in,
	input  wire hmmd_pkg::hmmd_dsel_t dsel_in,
	input  wire logic                 prd_in,
	output logic [21:0]               rom_rdata_out,
	output logic [21:0]               iram_rdata_out,
	output logic [7:0]                dram_rdata_out,
	output logic [7:0]                periph_rdata_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// Unselected targets show inverted data, so a stale value never matches
	assign rom_rdata_out    = {10'h155, rom_addr_in} ^ {22{!rom_sel_in}};
	assign iram_rdata_out   = {6'h2a, iram_addr_in} ^ {22{!iram_sel_in}};
	assign dram_rdata_out   = dreq_in.addr[7:0] ^ 8'h5a ^ {8{!(dsel_in.dram | dsel_in.dram_dbg)}};
	assign periph_rdata_out = dreq_in.addr[7:0] ^ 8'ha5 ^ {8{!prd_in}};
endmodule

// >>> verification/hmmd_decoder_tb.sv
// Self-checking bench for the host memory map decoder.
// Assumes the target model supplies read data; inputs change at falling edges.
module hmmd_decoder_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic                 sys_clk_in = 1'b0;
	logic                 rstn_in = 1'b0;
	logic [15:0]          iaddr_in = 16'h0000;
	logic                 ifetch_in = 1'b0;
	logic                 app_mode_in = 1'b0;
	logic                 dbg_mode_in = 1'b0;
	hmmd_pkg::hmmd_dreq_t dreq_in = '0;
	logic [21:0]          rom_rdata_in, iram_rdata_in, insn_out;
	logic [15:0]          iram_addr_out;
	logic [11:0]          rom_addr_out;
	logic [7:0]           dram_rdata_in, periph_rdata_in, drdata_out, derr_cnt_out;
	logic [2:0]           vector_idx_out;
	logic                 rom_sel_out, iram_sel_out, vector_hit_out, ifetch_err_out;
	logic                 dram_wr_out, periph_wr_out, periph_rd_out, dacc_err_out;
	hmmd_pkg::hmmd_isel_t isel_out;
	hmmd_pkg::hmmd_dsel_t dsel_out;
	int                   num_errors = 0;
	int                   num_checks = 0;

	always #5 sys_clk_in = ~sys_clk_in;

	hmmd_decoder u_hmmd_decoder (.sys_clk_in, .rstn_in, .iaddr_in, .ifetch_in, .app_mode_in,
		.rom_rdata_in, .iram_rdata_in, .rom_sel_out, .rom_addr_out, .iram_sel_out,
		.iram_addr_out, .insn_out, .vector_hit_out, .vector_idx_out, .ifetch_err_out,
		.isel_out, .dreq_in, .dbg_mode_in, .dram_rdata_in, .periph_rdata_in, .dsel_out,
		.dram_wr_out, .periph_wr_out, .periph_rd_out, .drdata_out, .dacc_err_out,
		.derr_cnt_out);
	hmmd_target_model u_hmmd_target_model (.rom_sel_in(rom_sel_out), .rom_addr_in(rom_addr_out),
		.iram_sel_in(iram_sel_out), .iram_addr_in(iram_addr_out), .dreq_in,
		.dsel_in(dsel_out), .prd_in(periph_rd_out), .rom_rdata_out(rom_rdata_in),
		.iram_rdata_out(iram_rdata_in), .dram_rdata_out(dram_rdata_in),
		.periph_rdata_out(periph_rdata_in));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH %0t decode got %h exp %h", $time, got, exp);
		end
	endtask

	// Decode is combinational, so results are sampled 2 ns after the change
	task automatic fetch(input logic [15:0] a, input logic app);
		@(negedge sys_clk_in);
		iaddr_in = a;
		ifetch_in = 1'b1;
		app_mode_in = app;
		#2;
	endtask

	task automatic dacc(input logic [15:0] a, input logic r, input logic w, input logic dbg);
		@(negedge sys_clk_in);
		dreq_in = '{addr: a, rd: r, wr: w};
		dbg_mode_in = dbg;
		#2;
	endtask

	task automatic t_err();
		for (int i = 0; i < 3; i++) begin
			dacc(16'h0038, 1'b0, 1'b1, 1'b0);
			chk({dsel_out.unmapped, dacc_err_out, periph_wr_out, dram_wr_out}, 4'b1100);
		end
		dacc(16'h003b, 1'b1, 1'b0, 1'b0);
		chk({derr_cnt_out, drdata_out}, 16'h0300);
	endtask

	task automatic t_rom();
		fetch(16'h0fff, 1'b0);
		chk({rom_sel_out, iram_sel_out, isel_out, rom_addr_out}, {6'b100010, 12'hfff});
		chk(insn_out, 22'h155fff);
		fetch(16'h1000, 1'b0);
		chk({rom_sel_out, isel_out, ifetch_err_out, insn_out}, {6'b000011, 22'h0});
	endtask

	task automatic t_iram();
		for (int i = 0; i < 5; i++) begin
			fetch(16'h2000 + 16'(i), 1'b1);
			chk({vector_hit_out, vector_idx_out, iram_addr_out}, {1'b1, 3'(i), 16'(i)});
			chk(insn_out, {6'h2a, 16'(i)});
		end
		fetch(16'h2005, 1'b1);
		chk({vector_hit_out, ifetch_err_out, isel_out}, 6'b000100);
		fetch(16'hbfb0, 1'b1);
		chk({iram_sel_out, ifetch_err_out, isel_out}, 6'b111000);
		fetch(16'hbfff, 1'b0);
		chk({iram_sel_out, ifetch_err_out, isel_out}, 6'b101000);
		fetch(16'hc000, 1'b0);
		chk({iram_sel_out, ifetch_err_out, isel_out}, 6'b010001);
	endtask

	task automatic t_map();
		logic [15:0] a [12] = '{16'h0010, 16'h001f, 16'h0037, 16'h003c, 16'h0047, 16'h004c,
			16'h0050, 16'h007d, 16'h004d, 16'h0100, 16'h2000, 16'h3fef};
		int          b [12] = '{15, 15, 12, 11, 10, 9, 8, 5, 0, 0, 2, 2};
		logic [7:0]  d;
		foreach (a[i]) begin
			dacc(a[i], 1'b1, 1'b0, 1'b0);
			d = (b[i] == 0) ? 8'h00 : a[i][7:0] ^ ((b[i] == 2) ? 8'h5a : 8'ha5);
			chk({dsel_out, dacc_err_out, drdata_out}, {16'h0001 << b[i], b[i] == 0, d});
			chk(periph_rd_out, b[i] > 2);
		end
	endtask

	task automatic t_dbg();
		dacc(16'h3ff0, 1'b0, 1'b1, 1'b0);
		chk({dsel_out.dram_dbg, dram_wr_out, dacc_err_out}, 3'b001);
		dacc(16'h3fff, 1'b0, 1'b1, 1'b1);
		chk({dsel_out.dram_dbg, dram_wr_out, dacc_err_out}, 3'b110);
		dacc(16'h0080, 1'b0, 1'b1, 1'b0);
		chk({dsel_out.dbgif, periph_wr_out}, 2'b00);
		dacc(16'h009f, 1'b0, 1'b1, 1'b1);
		chk({dsel_out.dbgif, periph_wr_out}, 2'b11);
		dacc(16'h2000, 1'b0, 1'b1, 1'b0);
		chk({dsel_out.dram, dram_wr_out, periph_wr_out}, 3'b110);
	endtask

	task automatic t_split();
		fetch(16'h0048, 1'b0);
		dacc(16'h0048, 1'b1, 1'b0, 1'b0);
		chk({rom_sel_out, insn_out[11:0], dsel_out.pmu, drdata_out}, {13'h1048, 9'h1ed});
	endtask

	// Refused accesses saturate the count; a mid-run reset clears it
	task automatic t_cnt();
		dacc(16'h0100, 1'b1, 1'b0, 1'b0);
		repeat (260) @(negedge sys_clk_in);
		chk(derr_cnt_out, 8'hff);
		rstn_in = 1'b0;
		#2;
		chk(derr_cnt_out, 8'h00);
		@(negedge sys_clk_in);
		rstn_in = 1'b1;
	endtask

	task automatic results();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	initial begin
		repeat (5) @(posedge sys_clk_in);
		@(negedge sys_clk_in);
		rstn_in = 1'b1;
		t_err();
		t_rom();
		t_iram();
		t_map();
		t_dbg();
		t_split();
		t_cnt();
		results();
	end

	// Bounded run: a hang counts as a mismatch
	initial begin
		repeat (2000) @(posedge sys_clk_in);
		num_errors++;
		results();
	end
endmodule

bind hmmd_decoder hmmd_decoder_properties u_hmmd_decoder_properties (.sys_clk_in, .rstn_in,
	.iaddr_in, .ifetch_in, .app_mode_in, .rom_sel_out, .rom_addr_out, .iram_sel_out,
	.vector_hit_out, .vector_idx_out, .ifetch_err_out, .dreq_in, .dbg_mode_in, .dsel_out,
	.dram_wr_out, .periph_wr_out, .drdata_out, .dacc_err_out);
